//--- hdl/bis_block_irq_status.sv
// Block level interrupt summary, channel gate and identification registers
`timescale 1ns/100ps
// What this block does
// - Summary bit 2 reads 1 while a channel two interrupt is pending.
// - Summary bit 1 reads 1 while a channel one interrupt is pending.
// - Summary bit 0 reads 1 while a channel zero interrupt is pending.
// - A set summary bit stays set until its source status is read or its gate bit is cleared.
// - Part identification at 0x3E is a fixed read-only byte.
// - Revision at 0x3F carries code in low nibble, zero high nibble.
// - A channel with its gate bit clear never shows a pending summary.
module bis_block_irq_status
  import bis_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5a, // Arbitrary identification value
  parameter logic [3:0] REV_CODE = 4'h3 // Arbitrary revision value
)
(
  input wire logic clk, // System clock, 125 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic sclk, // Serial clock from host
  input wire logic csSel, // Chip select, high during a frame
  input wire logic sdi, // Serial data in
  output logic sdoOut, // Serial data out
  output logic sdoOe, // Serial data out enable
  input wire logic [2:0] chanEvent, // Per-channel enabled source event, pulse
  output logic [2:0] srcStatusRead // Per-channel source status read, pulse
);
  logic [5:0] regAddr;
  logic [7:0] regWrData;
  logic regWrStrobe;
  logic regRdStrobe;
  logic [7:0] regRdData;
  logic [2:0] gate, next_gate;
  logic [2:0] summary, next_summary;
  logic gateWrite;

  ////////////////////////////////////////////////////////////////////////////
  // Serial front end
  bis_serial_port u_port (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .sclk(sclk),
    .csSel(csSel),
    .sdi(sdi),
    .sdoOut(sdoOut),
    .sdoOe(sdoOe),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe),
    .regRdData(regRdData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Source status address of a channel
  function automatic logic [5:0] src_addr(input int chan);
    logic [5:0] a;
    a = SRC_STATUS_CH0_ADDR;
    if (chan == CH1_BIT)
    begin
      a = SRC_STATUS_CH1_ADDR;
    end
    else if (chan == CH2_BIT)
    begin
      a = SRC_STATUS_CH2_ADDR;
    end
    return a;
  endfunction

  // Read of a source status register releases its channel summary
  always_comb
  begin
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      srcStatusRead[i] = regRdStrobe && ce && (regAddr == src_addr(i));
    end
  end

  assign gateWrite = regWrStrobe && (regAddr == BLOCK_GATE_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Gate and sticky summary; an event in the release cycle keeps the bit set
  always_comb
  begin
    next_gate = gate;
    if (gateWrite)
    begin
      next_gate = regWrData[2:0];
    end
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      // Set wins over release; clearing the gate drops everything
      next_summary[i] = next_gate[i] &&
        (chanEvent[i] || (summary[i] && !srcStatusRead[i]));
    end
  end

  // Gate and summary registers; reset acts even with the clock enable low
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gate <= GATE_RESET;
      summary <= SUMMARY_RESET;
    end
    else if (ce)
    begin
      gate <= next_gate;
      summary <= next_summary;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped and other-block addresses read zero
  always_comb
  begin
    unique case (regAddr)
      BLOCK_GATE_ADDR: regRdData = {5'h00, gate};
      BLOCK_SUMMARY_ADDR: regRdData = {5'h00, summary};
      PART_ID_ADDR: regRdData = PART_ID;
      SILICON_REV_ADDR: regRdData = {4'h0, REV_CODE};
      default: regRdData = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks: an enabled event flags its channel on the next edge
  chan2_set_a: assert property (@(posedge clk) disable iff (rst)
    (ce && chanEvent[CH2_BIT] && gate[CH2_BIT] && !gateWrite)
    |=> summary[CH2_BIT])
    else $error("channel two event not flagged");
  chan1_set_a: assert property (@(posedge clk) disable iff (rst)
    (ce && chanEvent[CH1_BIT] && gate[CH1_BIT] && !gateWrite)
    |=> summary[CH1_BIT])
    else $error("channel one event not flagged");
  chan0_set_a: assert property (@(posedge clk) disable iff (rst)
    (ce && chanEvent[CH0_BIT] && gate[CH0_BIT] && !gateWrite)
    |=> summary[CH0_BIT])
    else $error("channel zero event not flagged");

  // No event, no flag: a clear bit only rises on an enabled event
  chan2_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (!summary[CH2_BIT] && !(ce && chanEvent[CH2_BIT]))
    |=> !summary[CH2_BIT])
    else $error("channel two flag raised without event");
  chan1_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (!summary[CH1_BIT] && !(ce && chanEvent[CH1_BIT]))
    |=> !summary[CH1_BIT])
    else $error("channel one flag raised without event");
  chan0_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (!summary[CH0_BIT] && !(ce && chanEvent[CH0_BIT]))
    |=> !summary[CH0_BIT])
    else $error("channel zero flag raised without event");

  // A raised flag holds until its source status is read
  chan2_hold_a: assert property (@(posedge clk) disable iff (rst)
    (summary[CH2_BIT] && !srcStatusRead[CH2_BIT] && !gateWrite)
    |=> summary[CH2_BIT])
    else $error("channel two flag dropped without source read");
  summary_hold_a: assert property (@(posedge clk) disable iff (rst)
    (summary[CH1_BIT] && !srcStatusRead[CH1_BIT] && !gateWrite)
    |=> summary[CH1_BIT])
    else $error("summary dropped without source read");
  chan0_hold_a: assert property (@(posedge clk) disable iff (rst)
    (summary[CH0_BIT] && !srcStatusRead[CH0_BIT] && !gateWrite)
    |=> summary[CH0_BIT])
    else $error("channel zero flag dropped without source read");

  // A source read with no fresh event releases; a double pulse would eat an event
  chan2_free_a: assert property (@(posedge clk) disable iff (rst)
    (srcStatusRead[CH2_BIT] && !chanEvent[CH2_BIT])
    |=> !summary[CH2_BIT])
    else $error("channel two flag not released");
  chan1_free_a: assert property (@(posedge clk) disable iff (rst)
    (srcStatusRead[CH1_BIT] && !chanEvent[CH1_BIT])
    |=> !summary[CH1_BIT])
    else $error("channel one flag not released");
  chan0_free_a: assert property (@(posedge clk) disable iff (rst)
    (srcStatusRead[CH0_BIT] && !chanEvent[CH0_BIT])
    |=> !summary[CH0_BIT])
    else $error("channel zero flag not released");
  read_pulse_a: assert property (@(posedge clk) disable iff (rst)
    (srcStatusRead != 3'h0)
    |=> (srcStatusRead == 3'h0))
    else $error("source read pulse too long");

  // Gate: a write lands, a closed channel never flags, reset closes all
  gate_write_a: assert property (@(posedge clk) disable iff (rst)
    (ce && gateWrite)
    |=> ({5'h00, gate} == ($past(regWrData) & 8'h07)))
    else $error("gate write lost");
  gate_block_a: assert property (@(posedge clk) disable iff (rst)
    (summary & ~gate) == 3'h0)
    else $error("summary set on gated channel");
  gate_reset_a: assert property (@(posedge clk) disable iff (rst)
    $past(rst)
    |-> (gate == GATE_RESET))
    else $error("gate not cleared by reset");

  // Summary clears on reset and leaves the port with its bit 7 zero
  summary_reset_a: assert property (@(posedge clk) disable iff (rst)
    $past(rst)
    |-> (summary == SUMMARY_RESET))
    else $error("summary not cleared by reset");
  summary_read_a: assert property (@(posedge clk) disable iff (rst)
    (ce && regRdStrobe && regAddr == BLOCK_SUMMARY_ADDR)
    |=> !sdoOut)
    else $error("summary readback bit 7 set");

  // Identification bytes reach the port MSB first after the read strobe
  part_id_a: assert property (@(posedge clk) disable iff (rst)
    (ce && regRdStrobe && regAddr == PART_ID_ADDR)
    |=> (sdoOut == PART_ID[7]))
    else $error("part identification not returned");
  rev_read_a: assert property (@(posedge clk) disable iff (rst)
    (ce && regRdStrobe && regAddr == SILICON_REV_ADDR)
    |=> !sdoOut)
    else $error("revision byte upper nibble set");
endmodule

//--- hdl/bis_pkg.sv
// Shared constants for the block interrupt summary and identification registers
package bis_pkg;
  // Register byte offsets on the serial control port
  localparam logic [5:0] SRC_STATUS_CH0_ADDR = 6'h02;
  localparam logic [5:0] SRC_STATUS_CH1_ADDR = 6'h0a;
  localparam logic [5:0] SRC_STATUS_CH2_ADDR = 6'h12;
  localparam logic [5:0] BLOCK_GATE_ADDR = 6'h20;
  localparam logic [5:0] BLOCK_SUMMARY_ADDR = 6'h21;
  localparam logic [5:0] PART_ID_ADDR = 6'h3e;
  localparam logic [5:0] SILICON_REV_ADDR = 6'h3f;
  // Field positions and widths
  localparam int NUM_CHAN = 3;
  localparam int CH0_BIT = 0;
  localparam int CH1_BIT = 1;
  localparam int CH2_BIT = 2;
  localparam int REV_WIDTH = 4;
  // Reset values
  localparam logic [2:0] GATE_RESET = 3'h0;
  localparam logic [2:0] SUMMARY_RESET = 3'h0;
  // Serial frame layout: one read flag, six address bits, one spare, eight data
  localparam logic [4:0] FRAME_ADDR_LAST = 5'h07;
  localparam logic [4:0] FRAME_DATA_FIRST = 5'h08;
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  localparam logic [4:0] FRAME_LEN = 5'h10;
endpackage

//--- hdl/bis_serial_port.sv
// Serial control port slave: frames bits from the host into register accesses
`timescale 1ns/100ps
module bis_serial_port
  import bis_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic sclk, // Serial clock from host, sampled
  input wire logic csSel, // Chip select, high during a frame
  input wire logic sdi, // Serial data in
  output logic sdoOut, // Serial data out
  output logic sdoOe, // Serial data out enable
  output logic [5:0] regAddr, // Address of the access
  output logic [7:0] regWrData, // Write data
  output logic regWrStrobe, // One-cycle write pulse
  output logic regRdStrobe, // One-cycle read pulse
  input wire logic [7:0] regRdData // Read data for regAddr
);
  logic sclkPrev, next_sclkPrev;
  logic [4:0] bitCnt, next_bitCnt;
  logic [14:0] shiftIn, next_shiftIn;
  logic [7:0] shiftOut, next_shiftOut;
  logic isRead, next_isRead;
  logic [5:0] next_regAddr;
  logic [7:0] next_regWrData;
  logic next_regWrStrobe, next_regRdStrobe;
  logic sclkRise, sclkFall;

  ////////////////////////////////////////////////////////////////////////////
  // Edges of the sampled serial clock; host must hold each half for 4+ clocks
  assign sclkRise = sclk && !sclkPrev;
  assign sclkFall = !sclk && sclkPrev;
  assign sdoOut = shiftOut[7];
  assign sdoOe = csSel && isRead && (bitCnt >= FRAME_DATA_FIRST);

  // Frame sequencer; bits beyond the sixteenth are ignored
  always_comb
  begin
    next_sclkPrev = sclk;
    next_bitCnt = bitCnt;
    next_shiftIn = shiftIn;
    next_shiftOut = shiftOut;
    next_isRead = isRead;
    next_regAddr = regAddr;
    next_regWrData = regWrData;
    next_regWrStrobe = 1'b0;
    next_regRdStrobe = 1'b0;
    if (!csSel)
    begin
      next_bitCnt = 5'h00;
    end
    else if (sclkRise && bitCnt < FRAME_LEN)
    begin
      next_shiftIn = {shiftIn[13:0], sdi};
      next_bitCnt = bitCnt + 5'h01;
      if (bitCnt == 5'h00)
      begin
        next_isRead = sdi;
      end
      if (bitCnt == FRAME_ADDR_LAST)
      begin
        next_regAddr = shiftIn[5:0];
        next_regRdStrobe = isRead;
      end
      if (bitCnt == FRAME_LAST && !isRead)
      begin
        next_regWrData = {shiftIn[6:0], sdi};
        next_regWrStrobe = 1'b1;
      end
    end
    else if (sclkFall && isRead && bitCnt > FRAME_DATA_FIRST && bitCnt <= FRAME_LAST)
    begin
      next_shiftOut = {shiftOut[6:0], 1'b0};
    end
    // Read data is latched the cycle after the strobe, ahead of the next fall
    if (regRdStrobe)
    begin
      next_shiftOut = regRdData;
    end
  end

  // State registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sclkPrev <= 1'b0;
      bitCnt <= 5'h00;
      shiftIn <= 15'h0000;
      shiftOut <= 8'h00;
      isRead <= 1'b0;
      regAddr <= 6'h00;
      regWrData <= 8'h00;
      regWrStrobe <= 1'b0;
      regRdStrobe <= 1'b0;
    end
    else if (ce)
    begin
      sclkPrev <= next_sclkPrev;
      bitCnt <= next_bitCnt;
      shiftIn <= next_shiftIn;
      shiftOut <= next_shiftOut;
      isRead <= next_isRead;
      regAddr <= next_regAddr;
      regWrData <= next_regWrData;
      regWrStrobe <= next_regWrStrobe;
      regRdStrobe <= next_regRdStrobe;
    end
  end
endmodule

//--- verif/bis_host_model.sv
// Host model issuing serial register frames
`timescale 1ns/100ps
module bis_host_model
(
  input wire logic clk, // System clock
  output logic sclk, // Serial clock, still between frames
  output logic csSel, // Chip select
  output logic sdi, // Serial data to block
  input wire logic sdoOut, // Serial data from block
  input wire logic sdoOe // Serial data enable from block
);
  // Idle lines
  initial
  begin
    sclk = 1'b0;
    csSel = 1'b0;
    sdi = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // One frame, four clocks per serial half period
  task automatic xfer(input logic rw, input logic [5:0] a, input logic [7:0] wd,
    output logic [7:0] q);
    logic [15:0] fr;
    fr = {rw, a, 1'b0, wd};
    q = 8'h00;
    @(posedge clk);
    csSel <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      sclk <= 1'b0;
      // Released line toggles so a stale bit never passes
      sdi <= (rw && i > 7) ? ~sdi : fr[15-i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      // Undriven line reads inverted, so a missing enable corrupts the byte
      if (i > 7)
        q = {q[6:0], sdoOe ? sdoOut : ~sdoOut};
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    sclk <= 1'b0;
    repeat (2) @(posedge clk);
    csSel <= 1'b0;
    sdi <= ~sdi;
    repeat (2) @(posedge clk);
  endtask
endmodule

//--- verif/tb_top.sv
// Self-checking bench for the block summary and identification registers
`timescale 1ns/100ps
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin badCount++; \
  $display("wrong value %0t: got %h want %h", $time, g, e); end end
module tb_top;
  import bis_pkg::*;
  localparam logic [7:0] TB_PART = 8'hc4; // Arbitrary value
  localparam logic [3:0] TB_REV = 4'h9; // Arbitrary value
  logic clk, rst, ce, sclk, csSel, sdi, sdoOut, sdoOe;
  logic [2:0] chanEvent, srcStatusRead, seenRd;
  logic [7:0] q;
  int badCount = 0;
  int samplesChecked = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  bis_block_irq_status #(.PART_ID(TB_PART), .REV_CODE(TB_REV)) dut (.clk(clk), .rst(rst),
    .ce(ce), .sclk(sclk), .csSel(csSel), .sdi(sdi), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .chanEvent(chanEvent), .srcStatusRead(srcStatusRead));
  bis_host_model host (.clk(clk), .sclk(sclk), .csSel(csSel), .sdi(sdi), .sdoOut(sdoOut),
    .sdoOe(sdoOe));
  // Gather read pulses; a hang ends the run after a generous ceiling
  always @(posedge clk)
  begin
    if (rst)
      seenRd <= 3'h0;
    else
      seenRd <= seenRd | srcStatusRead;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      badCount++;
      wrapUp();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic wrapUp;
    if (badCount == 0 && samplesChecked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rdReg(input logic [5:0] a, input logic [7:0] e);
    host.xfer(1'b1, a, 8'h00, q);
    `CHK(q, e)
  endtask
  task automatic wrReg(input logic [5:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, q);
  endtask
  task automatic pulse(input logic [2:0] v);
    @(posedge clk);
    chanEvent <= v;
    @(posedge clk);
    chanEvent <= 3'h0;
  endtask
  // Reset values, fixed identity bytes, unmapped place
  task automatic t_ident;
    rdReg(BLOCK_SUMMARY_ADDR, 8'h00);
    rdReg(BLOCK_GATE_ADDR, 8'h00);
    wrReg(PART_ID_ADDR, ~TB_PART);
    rdReg(PART_ID_ADDR, TB_PART);
    wrReg(SILICON_REV_ADDR, 8'hff);
    rdReg(SILICON_REV_ADDR, {4'h0, TB_REV});
    rdReg(6'h30, 8'h00);
  endtask
  // Closed gate hides events and drops a pending flag
  task automatic t_gate;
    pulse(3'h7);
    rdReg(BLOCK_SUMMARY_ADDR, 8'h00);
    wrReg(BLOCK_GATE_ADDR, 8'h07);
    rdReg(BLOCK_GATE_ADDR, 8'h07);
    pulse(3'h1);
    wrReg(BLOCK_GATE_ADDR, 8'h06);
    rdReg(BLOCK_SUMMARY_ADDR, 8'h00);
    wrReg(BLOCK_GATE_ADDR, 8'h07);
  endtask
  // Each flag sets, holds across reads, clears on its source read
  task automatic t_chan;
    logic [5:0] src [3];
    src = '{SRC_STATUS_CH0_ADDR, SRC_STATUS_CH1_ADDR, SRC_STATUS_CH2_ADDR};
    for (int i = 0; i < 3; i++)
    begin
      pulse(3'h1 << i);
      rdReg(BLOCK_SUMMARY_ADDR, 8'h01 << i);
      rdReg(BLOCK_SUMMARY_ADDR, 8'h01 << i);
      `CHK(seenRd, (3'h1 << i) - 3'h1)
      rdReg(src[i], 8'h00);
      `CHK(seenRd, (3'h2 << i) - 3'h1)
      rdReg(BLOCK_SUMMARY_ADDR, 8'h00);
    end
    pulse(3'h7);
    wrReg(BLOCK_SUMMARY_ADDR, 8'hff);
    rdReg(BLOCK_SUMMARY_ADDR, 8'h07);
    rdReg(src[1], 8'h00);
    rdReg(BLOCK_SUMMARY_ADDR, 8'h05);
  endtask
  // Frozen clock enable hides an event; a mid-run reset clears flags and gate
  task automatic t_reset;
    @(posedge clk);
    ce <= 1'b0;
    pulse(3'h4);
    @(posedge clk);
    ce <= 1'b1;
    rdReg(BLOCK_SUMMARY_ADDR, 8'h00);
    pulse(3'h7);
    rdReg(BLOCK_SUMMARY_ADDR, 8'h07);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdReg(BLOCK_SUMMARY_ADDR, 8'h00);
    rdReg(BLOCK_GATE_ADDR, 8'h00);
    wrReg(BLOCK_GATE_ADDR, 8'h07);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    chanEvent = 3'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_ident();
    t_gate();
    t_reset();
    t_chan();
    wrapUp();
  end
endmodule
